/* File: inc/rcu_pkg.sv */
`default_nettype none
// Shared constants and types of the reset controller
package rcu_pkg;
    // Number of reset-requesting on-chip sources
    localparam int unsigned SRC_N        = 5;
    // Bit positions of the system reset request sources
    localparam int unsigned SRC_SW_POS   = 0;
    localparam int unsigned SRC_PWR_POS  = 1;
    localparam int unsigned SRC_EVT_POS  = 2;
    localparam int unsigned SRC_TRG_POS  = 3;
    localparam int unsigned SRC_EMU_POS  = 4;
    // Number of functional units served
    localparam int unsigned UNIT_N       = 4;
    // Synchroniser depth for the external reset input
    localparam int unsigned SYNC_STAGES  = 2;
    // Time a system reset is held, in ns, and its count in cycles
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned SYS_HOLD_NS  = 80;
    localparam int unsigned SYS_HOLD_CYC = (SYS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Gap between releasing successive units, in cycles
    localparam int unsigned STAGGER_CYC  = 2;
    // Counter width
    localparam int unsigned CNT_W        = 8;
    // Reset value of the cause record
    localparam logic [SRC_N-1:0] CAUSE_RST = 5'h00;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        RCU_HW_RESET  = 4'h1,
        RCU_SYS_HOLD  = 4'h2,
        RCU_RELEASE   = 4'h4,
        RCU_RUN       = 4'h8
    } rcu_state_t;
endpackage : rcu_pkg
`default_nettype wire

/* File: rtl/rcu_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// Reset synchroniser: asserts at once, releases on a clean clock edge
module rcu_sync #(
    parameter int unsigned STAGES = 2
) (
    input  wire logic clk_sys_in,   // System clock
    input  wire logic resetn_in,    // Combined asynchronous reset, active low
    output logic      sync_rst_n_out // Synchronised reset, active low
);
    // Shift chain; only the last stage is read outside
    logic [STAGES-1:0] chain_r;
    logic [STAGES-1:0] chain_nxt;

    // Shift a one in from the bottom
    always_comb begin
        chain_nxt = {chain_r[STAGES-2:0], 1'h1};
    end

    // Chain clears asynchronously, fills synchronously
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            chain_r <= '0;
        end else begin
            chain_r <= chain_nxt;
        end
    end

    assign sync_rst_n_out = chain_r[STAGES-1];
endmodule : rcu_sync
`default_nettype wire

/* File: rtl/rcu_reset_controller.sv */
`timescale 1ns/1ps
`default_nettype none
module rcu_reset_controller
    import rcu_pkg::*;
#(
    parameter int unsigned UNITS   = rcu_pkg::UNIT_N,
    parameter int unsigned HOLD    = rcu_pkg::SYS_HOLD_CYC,
    parameter int unsigned STAGGER = rcu_pkg::STAGGER_CYC
) (
    input  wire logic                      clk_sys_in,          // System clock, 125 MHz
    input  wire logic                      resetn_in,           // Power-on reset, active low
    input  wire logic                      clk_en_in,           // Clock enable, freezes state when low
    input  wire logic                      hw_reset_in_n,       // External hardware reset, active low
    input  wire logic                      reset_ctl_reg_wr_in, // Software write of reset request
    input  wire logic                      power_mgmt_unit_in,  // Reset request from power management
    input  wire logic                      system_event_ctrl_in,// Reset request from event controller
    input  wire logic                      trigger_router_in,   // Reset request from trigger routing
    input  wire logic                      emulator_in,         // Reset request from emulator
    output logic [UNITS-1:0]               unit_rst_n_out,      // Per-unit resets, active low; bit 0 is core
    output logic                           sys_reset_out,       // High while a system reset is in force
    output logic [rcu_pkg::SRC_N-1:0]      reset_cause_out      // Sources of the last system reset
);
    import rcu_pkg::*;

    // Combined asynchronous reset and its synchronised form
    logic hw_rst_n;      // Raw combined hardware reset
    logic hw_sync_n;     // Hardware reset released on a clock edge

    // Hardware reset: power-on or external pin pulled low
    assign hw_rst_n = resetn_in & hw_reset_in_n;

    // Release of the hardware reset is synchronised
    rcu_sync #(
        .STAGES         (SYNC_STAGES)
    ) u_sync (
        .clk_sys_in     (clk_sys_in),
        .resetn_in      (hw_rst_n),
        .sync_rst_n_out (hw_sync_n)
    );

    // Request vector from all system reset sources
    logic [SRC_N-1:0] req;
    assign req[SRC_SW_POS]  = reset_ctl_reg_wr_in;
    assign req[SRC_PWR_POS] = power_mgmt_unit_in;
    assign req[SRC_EVT_POS] = system_event_ctrl_in;
    assign req[SRC_TRG_POS] = trigger_router_in;
    assign req[SRC_EMU_POS] = emulator_in;

    // Walk of a system reset: accept in RUN, hold for HOLD cycles,
    // then free one unit every STAGGER+1 cycles from the top bit down.
    // The counter is CNT_W bits wide, so HOLD and STAGGER must fit in it.
    // A hardware reset walks the same release path, without the hold.

    // Sequencer state and counters
    rcu_state_t        state_r;     // Sequencer state
    rcu_state_t        state_nxt;   // Next sequencer state
    logic [CNT_W-1:0]  cnt_r;       // Hold and stagger counter
    logic [CNT_W-1:0]  cnt_nxt;     // Next counter value
    logic [UNITS-1:0]  rel_r;       // Released units, one bit each, bit 0 core
    logic [UNITS-1:0]  rel_nxt;     // Next release mask
    logic [SRC_N-1:0]  cause_r;     // Cause record, kept over system reset
    logic [SRC_N-1:0]  cause_nxt;   // Next cause record
    logic              sysrst_r;    // System reset in force
    logic              sysrst_nxt;  // Next system reset flag

    // Events decoded once and shared by every group
    logic              in_hw;       // Leaving hardware reset
    logic              in_hold;     // System reset hold phase
    logic              in_rel;      // Staggered release phase
    logic              in_run;      // All units free, requests honoured
    logic              cnt_done;    // Counter has run out
    logic              take;        // A request is accepted this cycle
    logic              step;        // One more unit is freed this cycle
    logic              last_step;   // The core is freed this cycle

    // Phase and event decode
    always_comb begin
        in_hw     = (state_r == RCU_HW_RESET);
        in_hold   = (state_r == RCU_SYS_HOLD);
        in_rel    = (state_r == RCU_RELEASE);
        in_run    = (state_r == RCU_RUN);
        cnt_done  = (cnt_r == '0);
        // Requests outside RUN are ignored until the walk is over
        take      = in_run && (|req);
        // A unit is freed each time the stagger count runs out
        step      = in_rel && cnt_done;
        // The unit above the core is free, so the core goes next
        last_step = step && rel_r[1];
    end

    // Next state and counter of the sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        unique case (state_r)
            // Leave hardware reset once the synchronised release is seen
            RCU_HW_RESET: begin
                state_nxt = RCU_RELEASE;
                cnt_nxt   = CNT_W'(STAGGER);
            end
            // Count the hold time down, then start the release walk
            RCU_SYS_HOLD: begin
                if (cnt_done) begin
                    state_nxt = RCU_RELEASE;
                    cnt_nxt   = CNT_W'(STAGGER);
                end else begin
                    cnt_nxt   = cnt_r - CNT_W'(1);
                end
            end
            // Space the releases STAGGER+1 cycles apart
            RCU_RELEASE: begin
                if (cnt_done) begin
                    cnt_nxt = CNT_W'(STAGGER);
                    // Core freed last, the walk is over
                    if (last_step) begin
                        state_nxt = RCU_RUN;
                    end
                end else begin
                    cnt_nxt = cnt_r - CNT_W'(1);
                end
            end
            // Running: any request starts a system reset
            RCU_RUN: begin
                if (take) begin
                    state_nxt = RCU_SYS_HOLD;
                    cnt_nxt   = CNT_W'(HOLD - 1);
                end
            end
            // An illegal code falls back to a fresh release walk
            default: begin
                state_nxt = RCU_HW_RESET;
            end
        endcase
    end

    // State and counter registers; the synchronised hardware reset clears them
    always_ff @(posedge clk_sys_in or negedge hw_sync_n) begin
        if (!hw_sync_n) begin
            state_r <= RCU_HW_RESET;
            cnt_r   <= '0;
        end else if (clk_en_in) begin
            // Clock enable low freezes the sequencer
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // Next release mask: cleared in reset, shifted down one unit per step
    always_comb begin
        rel_nxt = rel_r;
        if (in_hw || in_hold || take) begin
            // Every unit held in hardware reset, in the hold phase and on acceptance of a request
            rel_nxt = '0;
        end else if (step) begin
            // A one enters at the top; the core is reached last
            rel_nxt = {1'h1, rel_r[UNITS-1:1]};
        end
    end

    // Release mask register; units stay held through hardware reset
    always_ff @(posedge clk_sys_in or negedge hw_sync_n) begin
        if (!hw_sync_n) begin
            rel_r <= '0;
        end else if (clk_en_in) begin
            rel_r <= rel_nxt;
        end
    end

    // Next cause record: only an accepted request rewrites it
    always_comb begin
        cause_nxt = cause_r;
        if (take) begin
            // Every source high at acceptance is recorded together
            cause_nxt = req;
        end
    end

    // Cause record: a system reset leaves it alone, hardware reset clears it
    always_ff @(posedge clk_sys_in or negedge hw_sync_n) begin
        if (!hw_sync_n) begin
            cause_r <= CAUSE_RST;
        end else if (clk_en_in) begin
            cause_r <= cause_nxt;
        end
    end

    // Next system reset flag: set on acceptance, cleared as the core is freed
    always_comb begin
        sysrst_nxt = sysrst_r;
        if (in_hw || last_step) begin
            // No system reset after hardware reset or once the walk ends
            sysrst_nxt = 1'h0;
        end else if (take) begin
            sysrst_nxt = 1'h1;
        end
    end

    // System reset flag register
    always_ff @(posedge clk_sys_in or negedge hw_sync_n) begin
        if (!hw_sync_n) begin
            sysrst_r <= 1'h0;
        end else if (clk_en_in) begin
            sysrst_r <= sysrst_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign unit_rst_n_out  = rel_r;
    assign sys_reset_out   = sysrst_r;
    assign reset_cause_out = cause_r;
endmodule : rcu_reset_controller
`default_nettype wire

/* File: sim/rcu_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the reset sequencer
module rcu_checker #(
    parameter int UNITS   = rcu_pkg::UNIT_N,       // Units served
    parameter int HOLD    = rcu_pkg::SYS_HOLD_CYC, // Hold cycles of a system reset
    parameter int STAGGER = rcu_pkg::STAGGER_CYC   // Gap between releases
) (
    input wire logic                      clk_sys_in,
    input wire logic                      resetn_in,
    input wire logic                      clk_en_in,
    input wire logic                      hw_reset_in_n,
    input wire logic                      reset_ctl_reg_wr_in,
    input wire logic                      power_mgmt_unit_in,
    input wire logic                      system_event_ctrl_in,
    input wire logic                      trigger_router_in,
    input wire logic                      emulator_in,
    input wire logic [UNITS-1:0]          unit_rst_n_out,
    input wire logic                      sys_reset_out,
    input wire logic [rcu_pkg::SRC_N-1:0] reset_cause_out
);
    import rcu_pkg::*;
    localparam int D1 = HOLD + STAGGER + 2;            // Edges to first unit freed
    localparam int DK = HOLD + UNITS * (STAGGER + 1);  // Edges to core still held
    logic take;                                        // Request accepted this edge
    assign take = &unit_rst_n_out && clk_en_in && |{emulator_in, trigger_router_in,
        system_event_ctrl_in, power_mgmt_unit_in, reset_ctl_reg_wr_in};
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in || !hw_reset_in_n);
    sequence s_take;
        take;
    endsequence
    // Core still held, then everything free and system reset over
    sequence s_core_step;
        !unit_rst_n_out[0] ##1 (&unit_rst_n_out && !sys_reset_out);
    endsequence
    hold_units_a: assert property (sys_reset_out |-> !unit_rst_n_out[0])
        else $error("core free in reset");
    core_last_a: assert property ($rose(unit_rst_n_out[0]) |-> &unit_rst_n_out)
        else $error("core not last");
    take_req_a: assert property (s_take |=> unit_rst_n_out == '0 && sys_reset_out)
        else $error("request lost");
    cause_latch_a: assert property (s_take |=> reset_cause_out == $past({emulator_in, trigger_router_in,
        system_event_ctrl_in, power_mgmt_unit_in, reset_ctl_reg_wr_in}))
        else $error("cause wrong");
    cause_keep_a: assert property (!take |=> $stable(reset_cause_out))
        else $error("cause lost");
    first_rel_a: assert property (s_take |-> ##D1 unit_rst_n_out == {1'h1, {(UNITS-1){1'h0}}})
        else $error("first release");
    core_rel_a: assert property (s_take |-> ##DK s_core_step)
        else $error("core release");
    hw_hold_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        !hw_reset_in_n |=> unit_rst_n_out == '0 && reset_cause_out == '0 && !sys_reset_out)
        else $error("hw reset leak");
endmodule : rcu_checker
bind rcu_reset_controller rcu_checker #(.UNITS(UNITS), .HOLD(HOLD), .STAGGER(STAGGER)) rcu_checker_i (
    .clk_sys_in, .resetn_in, .clk_en_in, .hw_reset_in_n, .reset_ctl_reg_wr_in, .power_mgmt_unit_in,
    .system_event_ctrl_in, .trigger_router_in, .emulator_in, .unit_rst_n_out, .sys_reset_out, .reset_cause_out);
`default_nettype wire

/* File: sim/rcu_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// Reset pin and requesters; a requester drops its line once reset is seen
module rcu_partner (
    input  wire logic [4:0] want_in,
    input  wire logic       pin_low_in,
    input  wire logic       sys_reset_in,
    output logic [4:0]      req_out,
    output logic            hw_reset_n_out
);
    assign req_out = sys_reset_in ? 5'h00 : want_in;
    assign hw_reset_n_out = !pin_low_in;
endmodule : rcu_partner
`default_nettype wire

/* File: sim/reset_control_unit_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module reset_control_unit_bench;
    import rcu_pkg::*;
    localparam int DK = SYS_HOLD_CYC + UNIT_N * (STAGGER_CYC + 1); // Negedges to core still held
    logic       clk_sys_in = 1'h0;
    logic       resetn_in = 1'h0;
    logic       clk_en = 1'h1;
    logic [4:0] want = 5'h00;
    logic       pin_low = 1'h0;
    logic [4:0] req;
    logic       hw_n;
    logic [3:0] units;
    logic       sys_rst;
    logic [4:0] cause;
    int         bad_count = 0;
    int         samples_checked = 0;
    int         cyc = 0;
    always #4 clk_sys_in = !clk_sys_in;
    rcu_partner rcu_partner_i (.want_in(want), .pin_low_in(pin_low), .sys_reset_in(sys_rst), .req_out(req),
        .hw_reset_n_out(hw_n));
    rcu_reset_controller rcu_reset_controller_i (.clk_sys_in, .resetn_in, .clk_en_in(clk_en), .hw_reset_in_n(hw_n),
        .reset_ctl_reg_wr_in(req[0]), .power_mgmt_unit_in(req[1]), .system_event_ctrl_in(req[2]),
        .trigger_router_in(req[3]), .emulator_in(req[4]), .unit_rst_n_out(units), .sys_reset_out(sys_rst),
        .reset_cause_out(cause));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    // Bounded wait for every unit to be free
    task wait_run;
        for (int n = 0; n < 100 && units !== 4'hf; n++) @(negedge clk_sys_in);
    endtask : wait_run
    // One system reset request with full release walk
    task sys_req(input logic [4:0] mask);
        @(negedge clk_sys_in) want = mask;
        @(negedge clk_sys_in) want = 5'h00;
        check(8'({sys_rst, units}), 8'h10);
        check(8'(cause), 8'(mask));
        repeat (DK - 1) @(negedge clk_sys_in);
        check(8'(units), 8'h0e);
        @(negedge clk_sys_in);
        check(8'({sys_rst, units}), 8'h0f);
        check(8'(cause), 8'(mask));
        $display("test request %h done", mask);
    endtask : sys_req
    // Frozen clock enable ignores a request
    task t_freeze;
        @(negedge clk_sys_in) clk_en = 1'h0;
        want = 5'h01;
        repeat (3) @(negedge clk_sys_in);
        check(8'({sys_rst, units}), 8'h0f);
        want = 5'h00;
        @(negedge clk_sys_in) clk_en = 1'h1;
        check(8'(cause), 8'h0a);
        $display("test freeze done");
    endtask : t_freeze
    // External pin reset clears everything, release synchronised
    task t_hw;
        @(negedge clk_sys_in) pin_low = 1'h1;
        #1 check(8'({sys_rst, units}), 8'h00);
        check(8'(cause), 8'h00);
        @(negedge clk_sys_in) pin_low = 1'h0;
        @(negedge clk_sys_in);
        check(8'(units), 8'h00);
        wait_run;
        check(8'(units), 8'h0f);
        $display("test pin done");
    endtask : t_hw
    initial begin
        repeat (10) @(posedge clk_sys_in);
        @(negedge clk_sys_in) resetn_in = 1'h1;
        wait_run;
        check(8'(units), 8'h0f);
        for (int i = 0; i < SRC_N; i++) sys_req(5'h01 << i);
        sys_req(5'h1f);
        sys_req(5'h0a);
        t_freeze;
        t_hw;
        wrap_up;
    end
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            wrap_up;
        end
    end
endmodule : reset_control_unit_bench
`default_nettype wire
